// *** hw/pdp_consts.vh ***
// Constants of the port 6 data, pull-up and drive block
`ifndef PDP_CONSTS_VH
`define PDP_CONSTS_VH

// Register indices; byte address is four times the index
`define PDP_IDX_LATCH   24'hFFFFE5
`define PDP_IDX_PULLUP  24'hFF0015
`define PDP_IDX_DRIVE   24'hFF0035
`define PDP_IDX_DIR     24'hFFFFF5
`define PDP_IDX_MODE    24'hFFFFD5

// Upper byte-address bits that must be zero for a hit
`define PDP_ADDR_HI_ZERO 6'h00
// Byte offset inside the word of each register
`define PDP_WORD_LSBS   2'h0

// Reset value of every register
`define PDP_RST_REG     8'h00

// Port width
`define PDP_PORT_W      8

// AXI4-Lite response codes
`define PDP_RESP_OKAY   2'h0
`define PDP_RESP_DECERR 2'h3

`endif

// *** hw/pdp_reg8.v ***
// Eight-bit software register with write enable and synchronous clear
`timescale 1ns/10ps
`include "pdp_consts.vh"

module pdp_reg8 (
  clk,
  rst_n,
  wrEn,
  wrData,
  q
);
  input  wire       clk;     // System clock
  input  wire       rst_n;   // Synchronous reset, active low
  input  wire       wrEn;    // One-cycle write strobe
  input  wire [7:0] wrData;  // Value to store
  output wire [7:0] q;       // Stored value

  reg [7:0] q_r;             // Storage

  assign q = q_r;

  // Store on write, clear on reset
  always @(posedge clk) begin
    if (!rst_n) begin
      q_r <= `PDP_RST_REG;
    end else if (wrEn) begin
      q_r <= wrData;
    end
  end

endmodule // pdp_reg8

// *** hw/pdp_pin_cell.v ***
// Per-pin output, direction, pull-up and drive selection for one port pin
`timescale 1ns/10ps

module pdp_pin_cell (
  clk,
  rst_n,
  latchBit,
  dirBit,
  modeBit,
  pullBit,
  driveBit,
  periphOut,
  periphOe,
  pinOut,
  pinOe,
  pullUpEn,
  highDrive
);
  input  wire clk;        // System clock
  input  wire rst_n;      // Synchronous reset, active low
  input  wire latchBit;   // Stored output level
  input  wire dirBit;     // 1 output, 0 input
  input  wire modeBit;    // 0 general I/O, 1 mapped function
  input  wire pullBit;    // Pull-up request
  input  wire driveBit;   // High-current request
  input  wire periphOut;  // Mapped function output level
  input  wire periphOe;   // Mapped function drives the pin
  output reg  pinOut;     // Level toward the pad
  output reg  pinOe;      // Pad driver enable, high while driving
  output reg  pullUpEn;   // Pull-up device on
  output reg  highDrive;  // High-current drive on

  wire oeNxt;             // Driver enable before the flop
  wire outNxt;            // Output level before the flop
  wire isInput;           // Pin acts as an input in its current mode

  // Mapped function takes the pin when mode is 1, else general I/O
  assign oeNxt   = modeBit ? periphOe : dirBit;
  assign outNxt  = modeBit ? periphOut : latchBit;
  // General input or a mapped function that does not drive
  assign isInput = modeBit ? ~periphOe : ~dirBit;

  // Register every pad control so the pad sees clean levels
  always @(posedge clk) begin
    if (!rst_n) begin
      pinOut    <= 1'b0;
      pinOe     <= 1'b0;
      pullUpEn  <= 1'b0;
      highDrive <= 1'b0;
    end else begin
      pinOut    <= outNxt;
      pinOe     <= oeNxt;
      pullUpEn  <= pullBit & isInput;
      highDrive <= driveBit & oeNxt;
    end
  end

endmodule // pdp_pin_cell

// *** hw/pdp_port6.v ***
// Port 6 general-purpose pin block with its AXI4-Lite register slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`include "pdp_consts.vh"

module pdp_port6 #(
  parameter PORT_W = `PDP_PORT_W  // Number of pins
) (
  clk,
  rst_n,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_awaddr,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_bresp,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_araddr,
  s_axi_rvalid,
  s_axi_rready,
  s_axi_rdata,
  s_axi_rresp,
  pinIn,
  pinOut,
  pinOe,
  pullUpEn,
  highDrive,
  periphOut,
  periphOe,
  periphIn
);
  input  wire              clk;            // System clock, 10 MHz
  input  wire              rst_n;          // Synchronous reset, active low
  input  wire              s_axi_awvalid;  // Write address valid
  output wire              s_axi_awready;  // Write address ready
  input  wire [31:0]       s_axi_awaddr;   // Write byte address
  input  wire              s_axi_wvalid;   // Write data valid
  output wire              s_axi_wready;   // Write data ready
  input  wire [31:0]       s_axi_wdata;    // Write data
  input  wire [3:0]        s_axi_wstrb;    // Write byte enables
  output wire              s_axi_bvalid;   // Write response valid
  input  wire              s_axi_bready;   // Write response ready
  output wire [1:0]        s_axi_bresp;    // Write response code
  input  wire              s_axi_arvalid;  // Read address valid
  output wire              s_axi_arready;  // Read address ready
  input  wire [31:0]       s_axi_araddr;   // Read byte address
  output wire              s_axi_rvalid;   // Read data valid
  input  wire              s_axi_rready;   // Read data ready
  output wire [31:0]       s_axi_rdata;    // Read data
  output wire [1:0]        s_axi_rresp;    // Read response code
  input  wire [PORT_W-1:0] pinIn;          // Sampled pad levels
  output wire [PORT_W-1:0] pinOut;         // Pad output levels
  output wire [PORT_W-1:0] pinOe;          // Pad driver enables
  output wire [PORT_W-1:0] pullUpEn;       // Pull-up device enables
  output wire [PORT_W-1:0] highDrive;      // High-current drive enables
  input  wire [PORT_W-1:0] periphOut;      // Mapped function levels
  input  wire [PORT_W-1:0] periphOe;       // Mapped function enables
  output wire [PORT_W-1:0] periphIn;       // Pad levels to mapped functions

  // Write channel state
  reg  [31:0] awAddr_r;     // Held write address
  reg  [7:0]  wData_r;      // Held low data byte
  reg         wLane0_r;     // Held lane 0 enable
  reg         awHeld_r;     // Address captured, write pending
  reg         wHeld_r;      // Data captured, write pending
  reg         awready_r;    // Address ready flop
  reg         wready_r;     // Data ready flop
  reg         bvalid_r;     // Response valid flop
  reg  [1:0]  bresp_r;      // Response code flop
  // Read channel state
  reg         arready_r;    // Read address ready flop
  reg         rvalid_r;     // Read data valid flop
  reg  [7:0]  rdata_r;      // Read data byte flop
  reg  [1:0]  rresp_r;      // Read response code flop
  // Pad levels toward mapped functions
  reg  [PORT_W-1:0] periphIn_r;

  // Next values
  reg         awHeld_nxt;
  reg         wHeld_nxt;
  reg         bvalid_nxt;
  reg         rvalid_nxt;
  reg  [7:0]  rdData_nxt;   // Read mux result
  reg         rdHit_nxt;    // Read address maps to a register

  // Handshakes and decode
  wire        awTake;       // Write address taken this edge
  wire        wTake;        // Write data taken this edge
  wire        arTake;       // Read address taken this edge
  wire        doWrite;      // Both halves present, commit now
  wire        wrHit;        // Held write address maps to a register
  wire [4:0]  wrSel;        // Per-register write hit
  wire [4:0]  wrEn;         // Per-register write strobe

  // Register contents
  wire [7:0]  latchQ;       // Output data latch
  wire [7:0]  pullQ;        // Pull-up enables
  wire [7:0]  driveQ;       // Drive strength selects
  wire [7:0]  dirQ;         // Direction bits
  wire [7:0]  modeQ;        // Function select bits
  wire [7:0]  latchRead;    // Data register readback

  // True when a byte address selects the register at an index
  function hitIdx;
    input [31:0] addr;
    input [23:0] idx;
    begin
      hitIdx = (addr == {`PDP_ADDR_HI_ZERO, idx, `PDP_WORD_LSBS});
    end
  endfunction

  // Bus outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = {24'h000000, rdata_r};
  assign s_axi_rresp   = rresp_r;
  assign periphIn      = periphIn_r;

  // Channel handshakes
  assign awTake  = s_axi_awvalid & awready_r;
  assign wTake   = s_axi_wvalid & wready_r;
  assign arTake  = s_axi_arvalid & arready_r;
  // Commit once both halves are held and no response is waiting
  assign doWrite = awHeld_r & wHeld_r & ~bvalid_r;

  // Write address decode
  assign wrSel[0] = hitIdx(awAddr_r, `PDP_IDX_LATCH);
  assign wrSel[1] = hitIdx(awAddr_r, `PDP_IDX_PULLUP);
  assign wrSel[2] = hitIdx(awAddr_r, `PDP_IDX_DRIVE);
  assign wrSel[3] = hitIdx(awAddr_r, `PDP_IDX_DIR);
  assign wrSel[4] = hitIdx(awAddr_r, `PDP_IDX_MODE);
  assign wrHit    = |wrSel;
  // Only lane 0 carries register bits; the latch takes the write
  // whatever the direction, so the level is ready when it turns output
  assign wrEn     = wrSel & {5{doWrite & wLane0_r}};

  // Write channel next state
  always @* begin
    awHeld_nxt = (awHeld_r | awTake) & ~doWrite;
    wHeld_nxt  = (wHeld_r | wTake) & ~doWrite;
    bvalid_nxt = doWrite | (bvalid_r & ~s_axi_bready);
  end

  // Write channel flops; ready drops while a half or a reply is held
  always @(posedge clk) begin
    if (!rst_n) begin
      awAddr_r  <= 32'h00000000;
      wData_r   <= `PDP_RST_REG;
      wLane0_r  <= 1'b0;
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `PDP_RESP_OKAY;
    end else begin
      // Capture address half
      if (awTake) begin
        awAddr_r <= s_axi_awaddr;
      end
      // Capture data half
      if (wTake) begin
        wData_r  <= s_axi_wdata[7:0];
        wLane0_r <= s_axi_wstrb[0];
      end
      // Reply code fixed at commit
      if (doWrite) begin
        bresp_r <= wrHit ? `PDP_RESP_OKAY : `PDP_RESP_DECERR;
      end
      awHeld_r  <= awHeld_nxt;
      wHeld_r   <= wHeld_nxt;
      bvalid_r  <= bvalid_nxt;
      awready_r <= ~awHeld_nxt & ~bvalid_nxt;
      wready_r  <= ~wHeld_nxt & ~bvalid_nxt;
    end
  end

  // Software registers
  pdp_reg8 uLatch (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (wrEn[0]),
    .wrData (wData_r),
    .q      (latchQ)
  );

  pdp_reg8 uPull (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (wrEn[1]),
    .wrData (wData_r),
    .q      (pullQ)
  );

  pdp_reg8 uDrive (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (wrEn[2]),
    .wrData (wData_r),
    .q      (driveQ)
  );

  pdp_reg8 uDir (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (wrEn[3]),
    .wrData (wData_r),
    .q      (dirQ)
  );

  pdp_reg8 uMode (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (wrEn[4]),
    .wrData (wData_r),
    .q      (modeQ)
  );

  // Data readback: latch for outputs, pad level for inputs
  assign latchRead = (dirQ & latchQ) | (~dirQ & pinIn);

  // Read mux on the offered address; unmapped reads return zero
  always @* begin
    rdData_nxt = `PDP_RST_REG;
    rdHit_nxt  = 1'b1;
    if (hitIdx(s_axi_araddr, `PDP_IDX_LATCH)) begin
      rdData_nxt = latchRead;
    end else if (hitIdx(s_axi_araddr, `PDP_IDX_PULLUP)) begin
      rdData_nxt = pullQ;
    end else if (hitIdx(s_axi_araddr, `PDP_IDX_DRIVE)) begin
      rdData_nxt = driveQ;
    end else if (hitIdx(s_axi_araddr, `PDP_IDX_DIR)) begin
      rdData_nxt = dirQ;
    end else if (hitIdx(s_axi_araddr, `PDP_IDX_MODE)) begin
      rdData_nxt = modeQ;
    end else begin
      rdHit_nxt = 1'b0;
    end
  end

  // Read channel next state
  always @* begin
    rvalid_nxt = arTake | (rvalid_r & ~s_axi_rready);
  end

  // Read channel flops; data is sampled at the address edge
  always @(posedge clk) begin
    if (!rst_n) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= `PDP_RST_REG;
      rresp_r   <= `PDP_RESP_OKAY;
    end else begin
      // Latch answer with the address
      if (arTake) begin
        rdata_r <= rdData_nxt;
        rresp_r <= rdHit_nxt ? `PDP_RESP_OKAY : `PDP_RESP_DECERR;
      end
      rvalid_r  <= rvalid_nxt;
      arready_r <= ~rvalid_nxt;
    end
  end

  // Pad levels handed on to the mapped functions
  always @(posedge clk) begin
    if (!rst_n) begin
      periphIn_r <= {PORT_W{1'b0}};
    end else begin
      periphIn_r <= pinIn;
    end
  end

  // One pin cell per pad
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi = gi + 1) begin : gPin
      pdp_pin_cell uCell (
        .clk       (clk),
        .rst_n     (rst_n),
        .latchBit  (latchQ[gi]),
        .dirBit    (dirQ[gi]),
        .modeBit   (modeQ[gi]),
        .pullBit   (pullQ[gi]),
        .driveBit  (driveQ[gi]),
        .periphOut (periphOut[gi]),
        .periphOe  (periphOe[gi]),
        .pinOut    (pinOut[gi]),
        .pinOe     (pinOe[gi]),
        .pullUpEn  (pullUpEn[gi]),
        .highDrive (highDrive[gi])
      );
    end
  endgenerate

endmodule // pdp_port6

// *** bench/pdp_pad_model.sv ***
// Pad model of the eight port 6 pins as seen from outside the device
`timescale 1ns/10ps

module pdp_pad_model (
  input logic       clk,
  input logic [7:0] pinOut,
  input logic [7:0] pinOe,
  input logic [7:0] pullUpEn,
  input logic [7:0] extLevel,
  input logic [7:0] extDrive,
  output logic [7:0] pinIn
);
  logic flt = 1'b0;  // Level of a pin nobody holds

  // An undriven pin without pull-up wanders, so it never reads as a fixed value
  always @(posedge clk) begin
    flt <= ~flt;
  end

  // Pad level: own driver first, then outside driver, then pull-up
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive & extLevel)
               | (~pinOe & ~extDrive & (pullUpEn | {8{flt}}));
endmodule  // pdp_pad_model

// *** bench/pdp_port6_chk.sv ***
// Bus and pin checks on the port 6 block's ports
`timescale 1ns/10ps

module pdp_port6_chk #(
  parameter PORT_W = 8
) (
  input logic              clk,
  input logic              rst_n,
  input logic              s_axi_awvalid,
  input logic              s_axi_awready,
  input logic              s_axi_wvalid,
  input logic              s_axi_wready,
  input logic              s_axi_bvalid,
  input logic              s_axi_bready,
  input logic [1:0]        s_axi_bresp,
  input logic              s_axi_arvalid,
  input logic              s_axi_arready,
  input logic              s_axi_rvalid,
  input logic              s_axi_rready,
  input logic [31:0]       s_axi_rdata,
  input logic [PORT_W-1:0] pinIn,
  input logic [PORT_W-1:0] pinOe,
  input logic [PORT_W-1:0] pullUpEn,
  input logic [PORT_W-1:0] highDrive,
  input logic [PORT_W-1:0] periphIn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Address and data taken together
  sequence wrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken
  sequence rdTake;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // Both halves are held one edge, the commit edge raises the response
  chk_write_answer: assert property (wrTake |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after take");
  chk_write_blocks: assert property (wrTake |=> !s_axi_awready && !s_axi_wready)
    else $error("write channels still ready");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (rdTake |=> s_axi_rvalid && s_axi_rdata[31:8] == 0)
    else $error("read answer late or wide");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready too soon");
  chk_pull_inputs: assert property ((pullUpEn & pinOe) == 0)
    else $error("pull-up on a driven pin");
  chk_drive_outputs: assert property ((highDrive & ~pinOe) == 0)
    else $error("high drive on an input pin");
  chk_pad_sample: assert property ($past(rst_n) |-> periphIn == $past(pinIn))
    else $error("mapped input not one clock behind pad");
endmodule  // pdp_port6_chk

bind pdp_port6 pdp_port6_chk #(.PORT_W(PORT_W)) chk (
  .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .pinIn(pinIn), .pinOe(pinOe), .pullUpEn(pullUpEn),
  .highDrive(highDrive), .periphIn(periphIn)
);

// *** bench/tb_top.sv ***
// Self-checking bench of the port 6 pin block
`timescale 1ns/10ps
`include "pdp_consts.vh"
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin nErrors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end

module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [31:0] awAddr = 32'h0, wData = 32'h0, arAddr = 32'h0, rData;
  logic [3:0]  wStrb = 4'h0;
  logic [7:0]  periphOut = 8'h00, periphOe = 8'h00, extLevel = 8'h00, extDrive = 8'hFF;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp;
  logic [7:0]  pinIn, pinOut, pinOe, pullUpEn, highDrive, periphIn;
  int          nErrors = 0;
  int          testsRun = 0;

  // 10 MHz system clock
  always #50 clk = ~clk;

  pdp_port6 dut (
    .clk(clk), .rst_n(rst_n), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn), .highDrive(highDrive),
    .periphOut(periphOut), .periphOe(periphOe), .periphIn(periphIn)
  );

  pdp_pad_model pads (
    .clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
    .extLevel(extLevel), .extDrive(extDrive), .pinIn(pinIn)
  );

  // Register write; address and data offered together, each released once taken
  task automatic wr(input [23:0] idx, input [7:0] d, input [3:0] st, input [1:0] er);
    int n;
    @(posedge clk);
    awAddr <= {6'h00, idx, 2'h0};
    wData <= {24'h0, d};
    wStrb <= st;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      n++;
    end while (!bValid && n < 50);
    bReady <= 1'b0;
    `CHK({bValid, bResp}, {1'b1, er})
  endtask

  // Register read; compares response and full data word
  task automatic rd(input [23:0] idx, input [7:0] ed, input [1:0] er);
    int n;
    @(posedge clk);
    arAddr <= {6'h00, idx, 2'h0};
    arValid <= 1'b1;
    rReady <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (arReady) arValid <= 1'b0;
      n++;
    end while (!rValid && n < 50);
    rReady <= 1'b0;
    `CHK({rValid, rResp, rData}, {1'b1, er, 24'h0, ed})
  endtask

  // Reset values of the pull-up, drive, direction and mode registers and of the pin driver enables, pull-ups and high drive; latch address reads the pad
  task automatic tReset();
    rd(`PDP_IDX_LATCH, 8'h00, `PDP_RESP_OKAY);
    rd(`PDP_IDX_PULLUP, 8'h00, `PDP_RESP_OKAY);
    rd(`PDP_IDX_DRIVE, 8'h00, `PDP_RESP_OKAY);
    rd(`PDP_IDX_DIR, 8'h00, `PDP_RESP_OKAY);
    rd(`PDP_IDX_MODE, 8'h00, `PDP_RESP_OKAY);
    `CHK({pinOe, pullUpEn, highDrive}, 24'h0)
  endtask

  // Latch written while input, pin readback, then half the port turned to output
  task automatic tLatch();
    @(posedge clk);
    extLevel <= 8'h3C;
    wr(`PDP_IDX_LATCH, 8'hA5, 4'h1, `PDP_RESP_OKAY);
    rd(`PDP_IDX_LATCH, 8'h3C, `PDP_RESP_OKAY);
    wr(`PDP_IDX_LATCH, 8'h5A, 4'h0, `PDP_RESP_OKAY);
    @(posedge clk);
    extDrive <= 8'h0F;
    wr(`PDP_IDX_DIR, 8'hF0, 4'h1, `PDP_RESP_OKAY);
    rd(`PDP_IDX_LATCH, 8'hAC, `PDP_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK({pinOe, pinOut & 8'hF0}, {8'hF0, 8'hA0})
  endtask

  // Pull-ups on inputs only, mapped function on pins 0 and 1
  task automatic tPull();
    wr(`PDP_IDX_PULLUP, 8'hFF, 4'h1, `PDP_RESP_OKAY);
    @(posedge clk);
    periphOe <= 8'h01;
    periphOut <= 8'h01;
    extDrive <= 8'h0C;
    wr(`PDP_IDX_MODE, 8'h03, 4'h1, `PDP_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK({pinOe, pullUpEn, pinOut[0]}, {8'hF1, 8'h0E, 1'b1})
    rd(`PDP_IDX_LATCH, 8'hAF, `PDP_RESP_OKAY);
    wr(`PDP_IDX_PULLUP, 8'h00, 4'h1, `PDP_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(pullUpEn, 8'h00)
  endtask

  // High-current drive only on driven pins, per bit
  task automatic tDrive();
    wr(`PDP_IDX_DRIVE, 8'hFF, 4'h1, `PDP_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(highDrive, 8'hF1)
    wr(`PDP_IDX_DRIVE, 8'h21, 4'h1, `PDP_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(highDrive, 8'h21)
  endtask

  // Unmapped place refuses both directions
  task automatic tBad();
    wr(24'h000001, 8'hFF, 4'h1, `PDP_RESP_DECERR);
    rd(24'h000001, 8'h00, `PDP_RESP_DECERR);
  endtask

  // Verdict and end of run
  task automatic tallyAndFinish();
    $display("Checks run %0d, mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    tReset();
    tLatch();
    tPull();
    tDrive();
    tBad();
    tallyAndFinish();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    nErrors++;
    tallyAndFinish();
  end
endmodule  // tb_top
